// File: core/dsg_pkg.sv
// Shared constants for the strobe delay, gating and leveling block.
`default_nettype none
package dsg_pkg;
	// Wishbone register map, byte addresses.
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_DELAY = 8'h04;
	localparam logic [7:0] ADR_OFFSET = 8'h08;
	localparam logic [7:0] ADR_LEVEL = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;

	// Control register fields and reset value (four elements in use).
	localparam int unsigned CTRL_SRC_CORE = 0;
	localparam int unsigned CTRL_BYPASS = 1;
	localparam int unsigned CTRL_OFF_EN = 2;
	localparam int unsigned CTRL_FIVE_BIT = 3;
	localparam int unsigned CTRL_HALF_RATE = 4;
	localparam int unsigned CTRL_EN_FABRIC = 5;
	localparam int unsigned CTRL_UPD_USER = 6;
	localparam int unsigned CTRL_CNT_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0300;
	localparam logic [31:0] CTRL_MASK = 32'h0000_037F;
	localparam logic [31:0] DELAY_MASK = 32'h0000_003F;
	localparam logic [31:0] OFFSET_MASK = 32'h0000_007F;
	localparam logic [31:0] LEVEL_MASK = 32'h0000_0777;
	localparam int unsigned OFF_SUB = 6;
	localparam int unsigned LVL_WR_LSB = 0;
	localparam int unsigned LVL_RS_LSB = 4;
	localparam int unsigned LVL_PA_LSB = 8;

	// Status register fields.
	localparam int unsigned ST_SET_LSB = 0;
	localparam int unsigned ST_FIRST_LSB = 8;
	localparam int unsigned ST_GATE = 16;
	localparam int unsigned ST_ODT = 17;

	// Delay setting ranges.
	localparam int unsigned SET_W = 6;
	localparam logic [6:0] SET_MAX6 = 7'h3F;
	localparam logic [6:0] SET_MAX5 = 7'h1F;

	// Delay chain model, counted in core clock cycles.
	localparam logic [8:0] ELEM_INTR = 9'h001;
	localparam logic [9:0] LVL_INTR = 10'h001;
	localparam int unsigned STB_DEPTH = 257;
	localparam int unsigned LVL_DEPTH = 577;
	localparam int unsigned LVL_STAGES = 8;
	localparam int unsigned LVL_STEP_DEG = 45;
	localparam int unsigned LVL_MIN_FREQ_MHZ = 400;
	localparam logic [3:0] LVL_DQ_LAG = 4'h2;

	// Update enable fires once every eight rising edges of its source clock.
	localparam logic [2:0] UPD_CNT_LAST = 3'h7;

	// Positions of the pin inputs in the synchroniser vector.
	localparam int unsigned PIN_DQS = 0;
	localparam int unsigned PIN_REF = 1;
	localparam int unsigned PIN_USER = 2;
	localparam int unsigned PIN_WR = 3;
	localparam int unsigned PIN_RS = 4;
	localparam int unsigned PIN_DLL_LSB = 5;
	localparam int unsigned PIN_W = 11;
endpackage
`default_nettype wire

// File: core/dsg_delay_line.sv
// Tapped shift line that models a chain of delay elements in core clock cycles.
`default_nettype none
module dsg_delay_line #(
	parameter int unsigned DEPTH = 257
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic d_i,
	output logic [DEPTH-1:0] taps_o
);
	logic [DEPTH-1:0] line_r;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			line_r <= '0;
		end
		else
		begin
			line_r <= {line_r[DEPTH-2:0], d_i};
		end
	end

	// Tap k carries the input delayed by k+1 cycles.
	assign taps_o = line_r;
endmodule
`default_nettype wire

// File: core/dsg_strobe_core.sv
// Read strobe delay chain, update enable, postamble gating, leveling and termination control.
//
// Implementation choices: the address map and the Wishbone register port.
`default_nettype none
module dsg_strobe_core (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [dsg_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dqs_i,
	input wire logic ref_clk_i,
	input wire logic user_clk_i,
	input wire logic wr_clk_i,
	input wire logic resync_clk_i,
	input wire logic [dsg_pkg::SET_W-1:0] dll_delay_i,
	input wire logic dqs_en_i,
	input wire logic dqs_en_fabric_i,
	input wire logic rd_active_i,
	input wire logic wr_active_i,
	output logic dqs_delayed_o,
	output logic dqs_gated_o,
	output logic resync_clk_o,
	output logic hr_resync_clk_o,
	output logic wl_dqs_clk_o,
	output logic wl_dq_clk_o,
	output logic odt_en_o,
	output logic upd_en_o
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [5:0] gray2bin(input logic [5:0] g);
		logic [5:0] b;
		b = '0;
		b[5] = g[5];
		for (int i = 4; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel, input logic [31:0] keep);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r & keep;
	endfunction

	function automatic logic [9:0] lvl_idx(input logic [3:0] sel, input logic [9:0] stage);
		return 10'({6'h00, sel} * stage);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second.
	logic [dsg_pkg::PIN_W-1:0] sync1_r;
	logic [dsg_pkg::PIN_W-1:0] sync2_r;
	logic [dsg_pkg::PIN_W-1:0] prev_r;
	wire [dsg_pkg::PIN_W-1:0] pins_raw = {dll_delay_i, resync_clk_i, wr_clk_i, user_clk_i,
		ref_clk_i, dqs_i};

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, writes land on the ack edge.
	logic [31:0] ctrl_r;
	logic [31:0] delay_r;
	logic [31:0] offset_r;
	logic [31:0] level_r;
	logic [31:0] dat_r;
	logic ack_r;
	logic [31:0] status_w;
	wire wb_req = wb_cyc_i & wb_stb_i;
	wire wb_wr = wb_req & wb_we_i & ack_r;
	wire [31:0] rd_mux = (wb_adr_i == dsg_pkg::ADR_CTRL) ? ctrl_r :
		(wb_adr_i == dsg_pkg::ADR_DELAY) ? delay_r :
		(wb_adr_i == dsg_pkg::ADR_OFFSET) ? offset_r :
		(wb_adr_i == dsg_pkg::ADR_LEVEL) ? level_r :
		(wb_adr_i == dsg_pkg::ADR_STATUS) ? status_w : 32'h0000_0000;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ack_r <= 1'b0;
			dat_r <= '0;
			ctrl_r <= dsg_pkg::CTRL_RST;
			delay_r <= '0;
			offset_r <= '0;
			level_r <= '0;
		end
		else
		begin
			ack_r <= wb_req & ~ack_r;
			if (wb_req && !ack_r)
				dat_r <= rd_mux;
			if (wb_wr && wb_adr_i == dsg_pkg::ADR_CTRL)
				ctrl_r <= wmask(ctrl_r, wb_dat_i, wb_sel_i, dsg_pkg::CTRL_MASK);
			if (wb_wr && wb_adr_i == dsg_pkg::ADR_DELAY)
				delay_r <= wmask(delay_r, wb_dat_i, wb_sel_i, dsg_pkg::DELAY_MASK);
			if (wb_wr && wb_adr_i == dsg_pkg::ADR_OFFSET)
				offset_r <= wmask(offset_r, wb_dat_i, wb_sel_i, dsg_pkg::OFFSET_MASK);
			if (wb_wr && wb_adr_i == dsg_pkg::ADR_LEVEL)
				level_r <= wmask(level_r, wb_dat_i, wb_sel_i, dsg_pkg::LEVEL_MASK);
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////////////
	// Setting selection and update enable. Gray coding keeps the multi-bit DLL
	// setting safe to synchronise: only one bit moves per step.
	wire five_bit = ctrl_r[dsg_pkg::CTRL_FIVE_BIT];
	wire [5:0] set_gray = ctrl_r[dsg_pkg::CTRL_SRC_CORE] ? delay_r[5:0] :
		sync2_r[dsg_pkg::PIN_DLL_LSB +: dsg_pkg::SET_W];
	// A five-bit Gray word is the six-bit one with its top bit clear, so clear it first.
	wire [5:0] set_held = five_bit ? {1'b0, set_gray[4:0]} : set_gray;
	wire [5:0] set_bin = gray2bin(set_held);
	wire [5:0] off_bin = gray2bin(offset_r[5:0]);
	wire ref_rise = sync2_r[dsg_pkg::PIN_REF] & ~prev_r[dsg_pkg::PIN_REF];
	wire user_rise = sync2_r[dsg_pkg::PIN_USER] & ~prev_r[dsg_pkg::PIN_USER];
	wire upd_src_edge = ctrl_r[dsg_pkg::CTRL_UPD_USER] ? user_rise : ref_rise;
	logic [2:0] upd_cnt_r;
	logic upd_r;
	logic [5:0] set_app_r;
	logic [5:0] off_app_r;
	logic sub_app_r;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			upd_cnt_r <= '0;
			upd_r <= 1'b0;
			set_app_r <= '0;
			off_app_r <= '0;
			sub_app_r <= 1'b0;
		end
		else
		begin
			if (upd_src_edge)
				upd_cnt_r <= upd_cnt_r + 3'h1;
			upd_r <= upd_src_edge && upd_cnt_r == dsg_pkg::UPD_CNT_LAST;
			if (upd_r)
			begin
				set_app_r <= set_bin;
				off_app_r <= off_bin;
				sub_app_r <= offset_r[dsg_pkg::OFF_SUB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe delay chain: first element may carry the offset, clamped to range.
	wire [6:0] set_max = five_bit ? dsg_pkg::SET_MAX5 : dsg_pkg::SET_MAX6;
	wire [6:0] sum_add = {1'b0, set_app_r} + {1'b0, off_app_r};
	wire [5:0] first_add = (sum_add > set_max) ? set_max[5:0] : sum_add[5:0];
	wire [5:0] first_sub = (off_app_r > set_app_r) ? 6'h00 : set_app_r - off_app_r;
	wire [5:0] first_set = !ctrl_r[dsg_pkg::CTRL_OFF_EN] ? set_app_r :
		(sub_app_r ? first_sub : first_add);
	wire [1:0] elem_more = ctrl_r[dsg_pkg::CTRL_CNT_LSB +: 2];
	wire [8:0] elem_step = dsg_pkg::ELEM_INTR + {3'h0, set_app_r};
	wire [8:0] stb_idx = dsg_pkg::ELEM_INTR + {3'h0, first_set} +
		9'(elem_step * {7'h00, elem_more});
	wire [dsg_pkg::STB_DEPTH-1:0] stb_taps;

	dsg_delay_line #(
		.DEPTH(dsg_pkg::STB_DEPTH)
	) u_stb_chain (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.d_i(sync2_r[dsg_pkg::PIN_DQS]),
		.taps_o(stb_taps)
	);

	wire dqs_dly_nxt = ctrl_r[dsg_pkg::CTRL_BYPASS] ? sync2_r[dsg_pkg::PIN_DQS] :
		stb_taps[stb_idx];

	////////////////////////////////////////////////////////////////////////////////
	// Leveling chains: one write, one read, eight stages each of one element.
	wire [9:0] lvl_stage = dsg_pkg::LVL_INTR + {4'h0, set_app_r};
	wire [3:0] wr_sel = {1'b0, level_r[dsg_pkg::LVL_WR_LSB +: 3]};
	wire [9:0] wl_dqs_idx = lvl_idx(wr_sel, lvl_stage);
	wire [9:0] wl_dq_idx = lvl_idx(wr_sel + dsg_pkg::LVL_DQ_LAG, lvl_stage);
	wire [9:0] rs_idx = lvl_idx({1'b0, level_r[dsg_pkg::LVL_RS_LSB +: 3]}, lvl_stage);
	wire [9:0] pa_idx = lvl_idx({1'b0, level_r[dsg_pkg::LVL_PA_LSB +: 3]}, lvl_stage);
	wire [dsg_pkg::LVL_DEPTH-1:0] wr_taps;
	wire [dsg_pkg::LVL_DEPTH-1:0] rd_taps;

	dsg_delay_line #(
		.DEPTH(dsg_pkg::LVL_DEPTH)
	) u_wr_lvl (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.d_i(sync2_r[dsg_pkg::PIN_WR]),
		.taps_o(wr_taps)
	);

	dsg_delay_line #(
		.DEPTH(dsg_pkg::LVL_DEPTH)
	) u_rd_lvl (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.d_i(sync2_r[dsg_pkg::PIN_RS]),
		.taps_o(rd_taps)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Postamble gating. Both capture registers reset low so the strobe starts gated.
	logic wl_dqs_r;
	logic wl_dq_r;
	logic rs_r;
	logic rs_prev_r;
	logic pa_r;
	logic pa_prev_r;
	logic hr_clk_r;
	logic hr_cap_r;
	logic post_pos_r;
	logic post_neg_r;
	logic dqs_dly_r;
	logic dqs_gated_r;
	logic odt_r;
	wire rs_rise = rs_r & ~rs_prev_r;
	wire pa_rise = pa_r & ~pa_prev_r;
	wire pa_fall = ~pa_r & pa_prev_r;
	wire hr_rise = rs_rise & ~hr_clk_r;
	wire en_dedicated = ctrl_r[dsg_pkg::CTRL_HALF_RATE] ? hr_cap_r : dqs_en_i;
	wire en_src = ctrl_r[dsg_pkg::CTRL_EN_FABRIC] ? dqs_en_fabric_i : en_dedicated;
	wire gate_w = post_pos_r & post_neg_r;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wl_dqs_r <= 1'b0;
			wl_dq_r <= 1'b0;
			rs_r <= 1'b0;
			rs_prev_r <= 1'b0;
			pa_r <= 1'b0;
			pa_prev_r <= 1'b0;
			hr_clk_r <= 1'b0;
			hr_cap_r <= 1'b0;
			post_pos_r <= 1'b0;
			post_neg_r <= 1'b0;
			dqs_dly_r <= 1'b0;
			dqs_gated_r <= 1'b0;
			odt_r <= 1'b0;
		end
		else
		begin
			wl_dqs_r <= wr_taps[wl_dqs_idx];
			wl_dq_r <= wr_taps[wl_dq_idx];
			rs_r <= rd_taps[rs_idx];
			rs_prev_r <= rs_r;
			pa_r <= rd_taps[pa_idx];
			pa_prev_r <= pa_r;
			if (rs_rise)
				hr_clk_r <= ~hr_clk_r;
			if (hr_rise)
				hr_cap_r <= dqs_en_i;
			if (pa_rise)
				post_pos_r <= en_src;
			if (pa_fall)
				post_neg_r <= post_pos_r;
			dqs_dly_r <= dqs_dly_nxt;
			dqs_gated_r <= dqs_dly_nxt & gate_w;
			// A write wins over a read so the driver never sees its own termination.
			if (wr_active_i)
				odt_r <= 1'b0;
			else if (rd_active_i)
				odt_r <= 1'b1;
		end
	end

	assign status_w = (32'({26'h0, set_app_r}) << dsg_pkg::ST_SET_LSB) |
		(32'({26'h0, first_set}) << dsg_pkg::ST_FIRST_LSB) |
		(32'({31'h0, gate_w}) << dsg_pkg::ST_GATE) |
		(32'({31'h0, odt_r}) << dsg_pkg::ST_ODT);
	assign dqs_delayed_o = dqs_dly_r;
	assign dqs_gated_o = dqs_gated_r;
	assign resync_clk_o = rs_r;
	assign hr_resync_clk_o = hr_clk_r;
	assign wl_dqs_clk_o = wl_dqs_r;
	assign wl_dq_clk_o = wl_dq_r;
	assign odt_en_o = odt_r;
	assign upd_en_o = upd_r;

	////////////////////////////////////////////////////////////////////////////////
	a_upd_loads_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(set_app_r != $past(set_app_r)) |-> $past(upd_r))
		else $error("applied delay setting changed without update enable");
	a_five_bit_msb: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(upd_r && five_bit) |=> !set_app_r[5])
		else $error("five-bit mode loaded a nonzero setting MSB");
	a_bypass_zero_shift: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		ctrl_r[dsg_pkg::CTRL_BYPASS] |=> (dqs_dly_r == $past(sync2_r[dsg_pkg::PIN_DQS])))
		else $error("bypass did not pass the strobe straight through");
	a_gate_blocks_strobe: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!gate_w |=> !dqs_gated_r)
		else $error("strobe passed while the gate was closed");
	a_gate_open_half: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(gate_w && !$past(gate_w)) |-> $past(pa_fall))
		else $error("gate opened away from a postamble clock fall");
	a_post_clk_edge: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(post_pos_r != $past(post_pos_r)) |-> $past(pa_rise) && post_pos_r == $past(en_src))
		else $error("postamble register moved without a postamble clock rise");
	a_odt_write_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		wr_active_i |=> !odt_en_o)
		else $error("termination left on during a write");
	a_odt_read_on: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(rd_active_i && !wr_active_i) ##1 !wr_active_i [*2] |-> odt_en_o)
		else $error("termination not on during a read");
	a_hr_clk_toggle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		rs_rise |=> (hr_clk_r != $past(hr_clk_r)))
		else $error("half-rate clock missed a resync rise");
	a_wb_ack_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");
endmodule
`default_nettype wire

// File: bench/dsg_mem_model.sv
// Memory-side model that answers a read request with a strobe burst on the strobe pin.
`default_nettype none
module dsg_mem_model (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic go_i,
	output logic dqs_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	////////////////////////////////////////////////
	// Preamble low, burst, postamble low. Once released the pin returns high and
	// holds its last driven level until the next request.
	always @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt <= 0;
			dqs_o <= 1'b1;
		end
		else if (cnt == 0 && go_i)
		begin
			cnt <= 19;
			dqs_o <= 1'b0;
		end
		else if (cnt > 0)
		begin
			cnt <= cnt - 1;
			dqs_o <= cnt > 3 ? cnt[1] : cnt == 1;
		end
	end
endmodule
`default_nettype wire

// File: bench/dsg_strobe_core_tb.sv
// Self-checking bench for the strobe delay, gating and leveling block.
`default_nettype none
`define CHK(a, b) chk(32'(a), 32'(b))
module dsg_strobe_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = '0, rstn_i = '0, wb_cyc = '0, wb_stb = '0, wb_we = '0, wb_ack;
	logic [7:0] wb_adr = '0;
	logic [3:0] wb_sel = '0;
	logic [31:0] wb_wd = '0, wb_rd, q, rng = 32'h0000_0011;
	logic ref_clk = '0, usr_clk = '0, wr_clk = '0, rs_clk = '0, en = '0, en_f = '0;
	logic rd = '0, wr = '0, go = '0, exp_odt = '0, hr_p = '0, rs_p = '0;
	logic dqs, dly, gtd, rs_o, hr, wl_s, wl_d, odt, upd;
	logic [5:0] dll = '0;
	bit ref_run = 1, usr_run = 0, odt_on = 0;
	int cyc_n = 0, n_fail = 0, checks_done = 0, g_cnt = 0, nr = 0, nh = 0;
	int t, l, l0, d0, d1, lg;
	int cf [7][5] = '{'{0, 1, 0, 0, 0}, '{1, 1, 0, 0, 0}, '{2, 1, 0, 0, 0}, '{3, 1, 0, 0, 0},
		'{0, 0, 1, 0, 1}, '{1, 1, 1, 1, 1}, '{0, 0, 1, 1, 1}};
	int gc [5][4] = '{'{1, 0, 'h301, 1}, '{0, 0, 'h301, 0}, '{0, 1, 'h321, 1},
		'{1, 0, 'h321, 0}, '{1, 0, 'h311, 1}};

	dsg_strobe_core u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .dqs_i(dqs), .ref_clk_i(ref_clk),
		.user_clk_i(usr_clk), .wr_clk_i(wr_clk), .resync_clk_i(rs_clk), .dll_delay_i(dll),
		.dqs_en_i(en), .dqs_en_fabric_i(en_f), .rd_active_i(rd), .wr_active_i(wr),
		.dqs_delayed_o(dly), .dqs_gated_o(gtd), .resync_clk_o(rs_o), .hr_resync_clk_o(hr),
		.wl_dqs_clk_o(wl_s), .wl_dq_clk_o(wl_d), .odt_en_o(odt), .upd_en_o(upd));
	dsg_mem_model u_mem (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go), .dqs_o(dqs));

	////////////////////////////////////////////////
	initial
	begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i)
	begin
		cyc_n <= cyc_n + 1;
		if (ref_run && cyc_n[0])
			ref_clk <= ~ref_clk;
		if (usr_run && cyc_n[1:0] == 2'h3)
			usr_clk <= ~usr_clk;
		if (cyc_n[4:0] == 5'h00)
			wr_clk <= ~wr_clk;
		if (cyc_n[3:0] == 4'h8)
			rs_clk <= ~rs_clk;
		if (gtd === 1'b1)
			g_cnt <= g_cnt + 1;
		exp_odt <= wr ? 1'b0 : rd ? 1'b1 : exp_odt;
		rs_p <= rs_o;
		hr_p <= hr;
		if (rs_o === 1'b1 && rs_p === 1'b0)
			nr <= nr + 1;
		if (hr !== hr_p)
			nh <= nh + 1;
	end

	always @(negedge core_clk_i)
		if (odt_on)
			`CHK(odt, exp_odt);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic chk(input logic [31:0] a, input logic [31:0] b);
		checks_done++;
		if (a !== b)
		begin
			n_fail++;
			$display("Error at %0t ns: got %h expected %h", $time, a, b);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wd <= d;
		wb_sel <= s;
		for (t = 0; t < 50 && wb_ack !== 1'b1; t++)
			@(posedge core_clk_i);
		if (t == 50)
			n_fail++;
		q = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rg(input logic [7:0] a);
		bus(1'b0, a, '0, 4'hF);
	endtask

	// New settings only reach the chain on an update pulse, so every change waits for one.
	task automatic cfg(input logic [31:0] c, input logic [31:0] d, input logic [31:0] o);
		wrr(dsg_pkg::ADR_CTRL, c);
		wrr(dsg_pkg::ADR_DELAY, d);
		wrr(dsg_pkg::ADR_OFFSET, o);
		for (t = 0; t < 300 && upd !== 1'b1; t++)
			@(posedge core_clk_i);
		if (t == 300)
			n_fail++;
		repeat (3) @(posedge core_clk_i);
	endtask

	// Latency from the preamble falling edge at the pin to the delayed strobe falling.
	task automatic meas(output int r);
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		for (t = 0; t < 20 && dqs !== 1'b0; t++)
			@(posedge core_clk_i);
		r = cyc_n;
		for (t = 0; t < 100 && dly !== 1'b0; t++)
			@(posedge core_clk_i);
		r = cyc_n - r;
		repeat (90) @(posedge core_clk_i);
	endtask

	task automatic lvl(input bit s, output int r);
		for (t = 0; t < 80 && (s ? rs_clk : wr_clk) !== 1'b0; t++)
			@(posedge core_clk_i);
		for (t = 0; t < 80 && (s ? rs_clk : wr_clk) !== 1'b1; t++)
			@(posedge core_clk_i);
		r = cyc_n;
		for (t = 0; t < 80 && (s ? rs_o : wl_s) !== 1'b0; t++)
			@(posedge core_clk_i);
		for (t = 0; t < 80 && (s ? rs_o : wl_s) !== 1'b1; t++)
			@(posedge core_clk_i);
		r = cyc_n - r;
		lg = cyc_n;
		for (t = 0; t < 80 && wl_d !== 1'b1; t++)
			@(posedge core_clk_i);
		lg = cyc_n - lg;
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////
	initial
	begin
		#2000000;
		n_fail++;
		final_report();
	end

	initial
	begin
		repeat (20) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(posedge core_clk_i);
		rg(dsg_pkg::ADR_CTRL);
		`CHK(q, dsg_pkg::CTRL_RST);
		rg(8'h14);
		`CHK(q, 0);
		bus(1'b1, dsg_pkg::ADR_STATUS, '1, 4'hF);
		rg(dsg_pkg::ADR_STATUS);
		`CHK(q, 0);
		rng = xs(rng);
		wrr(dsg_pkg::ADR_LEVEL, rng);
		rg(dsg_pkg::ADR_LEVEL);
		`CHK(q, rng & dsg_pkg::LEVEL_MASK);
		bus(1'b1, dsg_pkg::ADR_OFFSET, '1, 4'h2);
		rg(dsg_pkg::ADR_OFFSET);
		`CHK(q, 0);
		$display("Register test done");
		ref_run <= 0;
		repeat (10) @(posedge core_clk_i);
		wrr(dsg_pkg::ADR_CTRL, 32'h0000_0301);
		wrr(dsg_pkg::ADR_DELAY, 32'h0000_0001);
		l = 0;
		repeat (60)
		begin
			@(posedge core_clk_i);
			l += int'(upd === 1'b1);
		end
		`CHK(l, 0);
		rg(dsg_pkg::ADR_STATUS);
		`CHK(q[5:0], 0);
		usr_run <= 1;
		cfg(32'h0000_0341, 32'h0000_0001, '0);
		`CHK(t < 300, 1);
		rg(dsg_pkg::ADR_STATUS);
		`CHK(q[5:0], 1);
		usr_run <= 0;
		ref_run <= 1;
		cfg(32'h0000_0309, 32'h0000_0021, '0);
		rg(dsg_pkg::ADR_STATUS);
		`CHK(q[5:0], 1);
		dll <= 6'h01;
		cfg(32'h0000_0300, '0, '0);
		rg(dsg_pkg::ADR_STATUS);
		`CHK(q[5:0], 1);
		$display("Update test done");
		cfg(32'h0000_0303, '0, '0);
		meas(l0);
		`CHK(l0, 3);
		foreach (cf[i])
		begin
			cfg(1 | cf[i][2] << 2 | cf[i][0] << 8, cf[i][1], cf[i][3] << 6 | cf[i][4]);
			d0 = cf[i][1] + (cf[i][3] ? -cf[i][4] : cf[i][4]) * cf[i][2];
			d0 = d0 < 0 ? 0 : d0;
			rg(dsg_pkg::ADR_STATUS);
			`CHK(q[13:8], d0);
			meas(l);
			`CHK(l - l0, 2 + d0 + cf[i][0] * (1 + cf[i][1]));
		end
		$display("Delay test done");
		`CHK(g_cnt, 0);
		wrr(dsg_pkg::ADR_LEVEL, 32'h0000_0300);
		foreach (gc[i])
		begin
			wrr(dsg_pkg::ADR_CTRL, gc[i][2]);
			en <= gc[i][0];
			en_f <= gc[i][1];
			repeat (100) @(posedge core_clk_i);
			d0 = g_cnt;
			meas(l);
			`CHK(g_cnt > d0, gc[i][3]);
		end
		$display("Gate test done");
		// Only one controller uses the shared leveling chains in this bench.
		cfg(32'h0000_0301, 32'h0000_0001, '0);
		for (int k = 0; k < 8; k++)
		begin
			wrr(dsg_pkg::ADR_LEVEL, k << 4 | k);
			repeat (70) @(posedge core_clk_i);
			lvl(1'b0, l);
			d0 = k ? d0 : l;
			`CHK(l - d0, 2 * k);
			`CHK(lg, 2 * dsg_pkg::LVL_DQ_LAG);
			lvl(1'b1, l);
			d1 = k ? d1 : l;
			`CHK(l - d1, 2 * k);
		end
		d0 = nr - nh;
		repeat (200) @(posedge core_clk_i);
		`CHK((nr - nh - d0) * (nr - nh - d0) < 2, 1);
		$display("Leveling test done");
		odt_on = 1;
		repeat (300)
		begin
			@(posedge core_clk_i);
			rng = xs(rng);
			rd <= rng[0];
			wr <= rng[1] & rng[2];
			en_f <= rng[3];
			dll <= rng[9:4];
		end
		odt_on = 0;
		$display("Termination test done");
		final_report();
	end
endmodule
`default_nettype wire
